/* File: bench/secl_eeprom_model.sv */
// serial eeprom behind its bus engine, one byte per request
`timescale 1ns/1ps
module secl_eeprom_model (
    input wire clk_i,
    input wire req_i,
    input wire wr_i,
    input wire [15:0] addr_i,
    input wire [7:0] wdata_i,
    input wire [1:0] mode_i,
    output logic done_o,
    output logic [7:0] rdata_o,
    output logic [2:0] err_o
);
    logic [7:0] mem [0:65535];
    logic [1:0] wait_c = 2'h0;
    initial begin
        done_o = 1'b0;
        rdata_o = 8'h00;
        err_o = 3'h0;
        for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
    end
    // answer delay follows the address, so prompt and slow replies mix
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        err_o <= 3'h0;
        rdata_o <= ~rdata_o;
        if (req_i && !done_o) begin
            wait_c <= wait_c + 2'h1;
            if (wait_c == addr_i[1:0]) begin
                wait_c <= 2'h0;
                done_o <= 1'b1;
                err_o <= 3'(4'h1 << mode_i >> 1);
                rdata_o <= mem[addr_i];
                if (wr_i && mode_i == 2'h0) mem[addr_i] <= wdata_i;
            end
        end
    end
endmodule

/* File: bench/secl_monitor.sv */
// concurrent checks on the ports of the eeprom loader
`timescale 1ns/1ps
module secl_monitor (
    input wire CLOCK_I,
    input wire NRST_I,
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PREADY_O,
    input wire CFG_WR_O,
    input wire [15:0] CFG_ADDR_O,
    input wire LOAD_DONE_O,
    input wire RESET_HALT_O,
    input wire [6:0] EE_TARGET_O,
    input wire EE_REQ_O,
    input wire [15:0] EE_ADDR_O,
    input wire EE_DONE_I,
    input wire EE_NACK_I,
    input wire EE_BUSERR_I
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!NRST_I);
    sequence s_fault; EE_REQ_O && EE_DONE_I && (EE_NACK_I || EE_BUSERR_I); endsequence
    sequence s_abort; RESET_HALT_O && LOAD_DONE_O; endsequence
    property p_target; $past(NRST_I) |-> EE_TARGET_O == 7'h50; endproperty
    a_target: assert property (p_target) else $error("eeprom target wrong");
    property p_req_hold; EE_REQ_O && !EE_DONE_I |=> EE_REQ_O && $stable(EE_ADDR_O); endproperty
    a_req_hold: assert property (p_req_hold) else $error("request moved early");
    property p_req_drop; EE_REQ_O && EE_DONE_I |=> !EE_REQ_O; endproperty
    a_req_drop: assert property (p_req_drop) else $error("request not dropped");
    property p_cfg_addr; CFG_WR_O |-> CFG_ADDR_O[1:0] == 2'h0; endproperty
    a_cfg_addr: assert property (p_cfg_addr) else $error("config address unaligned");
    property p_halt_done; $rose(RESET_HALT_O) |-> ##[0:3] LOAD_DONE_O; endproperty
    a_halt_done: assert property (p_halt_done) else $error("halt without done");
    property p_fault; s_fault |-> ##[1:4] s_abort; endproperty
    a_fault: assert property (p_fault) else $error("bus fault not aborted");
    property p_done_quiet; LOAD_DONE_O |-> !CFG_WR_O; endproperty
    a_done_quiet: assert property (p_done_quiet) else $error("write after done");
    property p_ready; PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O; endproperty
    a_ready: assert property (p_ready) else $error("apb answer late");
endmodule
bind secl_top secl_monitor mon_u (.CLOCK_I(CLOCK_I), .NRST_I(NRST_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O), .CFG_WR_O(CFG_WR_O), .CFG_ADDR_O(CFG_ADDR_O),
    .LOAD_DONE_O(LOAD_DONE_O), .RESET_HALT_O(RESET_HALT_O), .EE_TARGET_O(EE_TARGET_O),
    .EE_REQ_O(EE_REQ_O), .EE_ADDR_O(EE_ADDR_O), .EE_DONE_I(EE_DONE_I), .EE_NACK_I(EE_NACK_I),
    .EE_BUSERR_I(EE_BUSERR_I));

/* File: bench/tb_top.sv */
// self-checking bench for the eeprom configuration loader
`timescale 1ns/1ps
module tb_top;
    logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, chk = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, cfg_data, rd, dv;
    logic pready, pslverr, cfg_wr, halt, ldone, req, ewr, edone;
    logic [15:0] cfg_addr, eaddr;
    logic [7:0] ewdata, erdata, sum;
    logic [2:0] err;
    logic [1:0] mode = 0;
    logic [32:0] rq[$];
    logic [47:0] cq[$];
    logic [47:0] sts_exp = 48'h11_09_05_03_01_03;
    logic [5:0] hl = 6'b111101;
    int fail_count = 0, num_checks = 0, ptr;
    secl_top dut_u (.CLOCK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready),
        .PRDATA_O(prdata), .PSLVERR_O(pslverr), .CFG_WR_O(cfg_wr), .CFG_ADDR_O(cfg_addr),
        .CFG_DATA_O(cfg_data), .CFG_UNMAPPED_I(cfg_addr[15]), .RESET_HALT_O(halt),
        .LOAD_DONE_O(ldone), .EE_TARGET_O(), .EE_REQ_O(req), .EE_WR_O(ewr),
        .EE_ADDR_O(eaddr), .EE_WDATA_O(ewdata), .EE_DONE_I(edone), .EE_RDATA_I(erdata),
        .EE_NACK_I(err[0]), .EE_ARBLOST_I(err[1]), .EE_BUSERR_I(err[2]));
    secl_eeprom_model eem_u (.clk_i(clk), .req_i(req), .wr_i(ewr), .addr_i(eaddr),
        .wdata_i(ewdata), .mode_i(mode), .done_o(edone), .rdata_o(erdata), .err_o(err));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic cmp(input string s, input logic [47:0] e, input logic [47:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
        psel <= 1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        chk <= c;
        @(posedge clk);
        pen <= 1;
        // no cycle count assumed: only the watchdog ends a stuck wait
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 0;
        pen <= 0;
        chk <= 0;
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [32:0] e);
        rq.push_back(e);
        apb(0, a, 0, 1);
    endtask
    task automatic put(input logic [7:0] b);
        eem_u.mem[ptr] = b;
        sum += b;
        ptr++;
    endtask
    task automatic cfg_blk(input logic [13:0] da, input int cnt, input logic seq);
        put(da[7:0]);
        put({1'b0, seq, da[13:8]});
        if (seq) put(8'(cnt));
        if (seq) put(8'(cnt >> 8));
        for (int i = 0; i < cnt; i++) begin
            dv = $urandom;
            for (int j = 0; j < 4; j++) put(dv[8*j +: 8]);
            cq.push_back({da + 14'(i), 2'h0, dv});
        end
    endtask
    task automatic done_blk(input logic good);
        put(~(sum + 8'hC0) ^ {7'h0, !good});
        put(8'hC0);
    endtask
    task automatic wait_done;
        while (ldone !== 1'b1) @(posedge clk);
    endtask
    task automatic wait_busy;
        do apb(0, 8'h0C, 0, 0);
        while (rd[17] !== 1'b0);
    endtask
    always @(posedge clk) begin
        if (psel && pen && pready && !pwr && chk) begin
            cmp("apb read", rq.pop_front(), {pslverr, prdata});
        end
        if (cfg_wr) begin
            cmp("config write", cq.pop_front(), {cfg_addr, cfg_data});
        end
    end
    initial begin
        // several hundred cycles are needed; this leaves a wide margin
        #150000;
        fail_count++;
        give_verdict();
    end
    initial begin
        dv = $urandom(32'hEB6041E6);
        repeat (4) @(posedge clk);
        ptr = 0;
        sum = 0;
        cfg_blk(14'h0010, 1, 0);
        cfg_blk(14'h0020, 3, 1);
        cfg_blk(14'h2100, 1, 0);
        done_blk(1);
        nrst <= 1;
        wait_done();
        rd_chk(8'h04, 33'h21);
        rd_chk(8'h08, 33'h0);
        rd_chk(8'h20, 33'h1_0000_0000);
        $display("test clean load done");
        for (int k = 0; k < 6; k++) begin
            apb(1, 8'h04, 32'h3F, 0);
            apb(1, 8'h08, 0, 0);
            ptr = 0;
            sum = 0;
            if (k < 3) cfg_blk(14'h0030, 1, 0);
            if (k == 2) begin
                put(8'h00);
                put(8'h80);
            end else begin
                done_blk(0);
            end
            mode <= k > 2 ? 2'(k - 2) : 2'h0;
            apb(1, 8'h00, {30'h0, 1'b1, k == 1}, 0);
            wait_done();
            rd_chk(8'h04, sts_exp[8*k +: 8]);
            rd_chk(8'h08, hl[k]);
            $display("test fault case %0d done", k);
        end
        mode <= 0;
        dv = $urandom;
        apb(1, 8'h0C, 32'h0001_0100, 0);
        apb(1, 8'h10, {24'h0, dv[7:0]}, 0);
        wait_busy();
        rd_chk(8'h0C, 33'h0_0005_0100);
        apb(1, 8'h0C, 32'h0004_0100, 0);
        apb(1, 8'h10, 0, 0);
        wait_busy();
        rd_chk(8'h10, {25'h0, dv[7:0]});
        cmp("config writes left", 0, 48'(cq.size()));
        $display("test host access done");
        give_verdict();
    end
endmodule

/* File: design/secl_regs.vh */
// register map, field positions and codes of the eeprom loader
`ifndef SECL_REGS_VH
`define SECL_REGS_VH
`define SECL_OFS_CTRL 8'h00
`define SECL_OFS_STS 8'h04
`define SECL_OFS_SWITCH_CONTROL_REG 8'h08
`define SECL_OFS_HACC 8'h0C
`define SECL_OFS_HDATA 8'h10
`define SECL_CTRL_IGN 0
`define SECL_CTRL_RESTART 1
`define SECL_STS_DONE 0
`define SECL_STS_SUMERR 1
`define SECL_STS_NACK 2
`define SECL_STS_ARB 3
`define SECL_STS_MISC 4
`define SECL_STS_UNMAP 5
`define SECL_SW_HALT 0
`define SECL_HACC_DIR 16
`define SECL_HACC_BUSY 17
`define SECL_HACC_DONE 18
`define SECL_TYPE_SINGLE 2'h0
`define SECL_TYPE_SEQ 2'h1
`define SECL_TYPE_BAD 2'h2
`define SECL_TYPE_DONE 2'h3
`define SECL_TARGET 7'h50
`define SECL_SUM_OK 8'hFF
`define SECL_ADDR_LAST 16'hFFFF
`define SECL_ARB_LAST 4'hF
`endif

/* File: design/secl_top.v */
// serial eeprom configuration loader with apb registers and host path
//
// Summary of operation
// [RULE1] read bytes from address zero until done
// [RULE2] type 0: address, type, one dword
// [RULE3] byte address is dword address times four
// [RULE4] eeprom target address is 1010000b
// [RULE5] type 1: address, type, count, data dwords
// [RULE6] count spans one to 65535 dwords
// [RULE7] sequential data to consecutive dword addresses
// [RULE8] type 3 done block ends the load
// [RULE9] unmapped write dropped, flag set
// [RULE10] 8-bit sum over all bytes equals 0xFF
// [RULE11] image checksum byte is complemented sum
// [RULE12] ignore bit suppresses checksum error
// [RULE13] any load error stops and sets halt
// [RULE14] done flag set on finish or abort
// [RULE15] checksum mismatch: format error, halt, done
// [RULE16] address roll-over: format error, halt, abort
// [RULE17] type 2 invalid: format error, halt, abort
// [RULE18] nack: no-ack error, halt, abort
// [RULE19] 16 lost arbitrations: error, halt, abort
// [RULE20] misplaced start or stop: error, halt, abort
// [RULE21] host byte read started by data write
// [RULE22] host byte write started by data write
// [RULE23] host never starts while busy
// [RULE24] host access errors go to status
// [RULE25] count and data stored low byte first
// [RULE26] type sits in two top bits
`timescale 1ns/1ps
`include "secl_regs.vh"
module secl_top (
    input wire CLOCK_I,
    input wire NRST_I,
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [7:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    output reg PREADY_O,
    output reg [31:0] PRDATA_O,
    output reg PSLVERR_O,
    output reg CFG_WR_O,
    output reg [15:0] CFG_ADDR_O,
    output reg [31:0] CFG_DATA_O,
    input wire CFG_UNMAPPED_I,
    output reg RESET_HALT_O,
    output reg LOAD_DONE_O,
    output reg [6:0] EE_TARGET_O,
    output wire EE_REQ_O,
    output wire EE_WR_O,
    output wire [15:0] EE_ADDR_O,
    output wire [7:0] EE_WDATA_O,
    input wire EE_DONE_I,
    input wire [7:0] EE_RDATA_I,
    input wire EE_NACK_I,
    input wire EE_ARBLOST_I,
    input wire EE_BUSERR_I
);
    localparam ST_IDLE = 3'h0;
    localparam ST_FETCH = 3'h1;
    localparam ST_WRITE = 3'h2;
    localparam ST_CHECK = 3'h3;
    localparam ST_HOST = 3'h4;
    localparam PH_HDR0 = 3'h0;
    localparam PH_HDR1 = 3'h1;
    localparam PH_CNT0 = 3'h2;
    localparam PH_CNT1 = 3'h3;
    localparam PH_DATA = 3'h4;

    reg [2:0] state;
    reg [2:0] phase;
    reg load_run;
    reg wrapped;
    reg [15:0] ee_addr;
    reg [7:0] sum;
    reg [13:0] block_dword_address;
    reg [15:0] dword_count;
    reg [31:0] dw_data;
    reg [1:0] dbyte;
    reg ignore_sum_errors;
    reg sum_or_format_error;
    reg no_ack_error;
    reg lost_arbitration_error;
    reg misc_bus_error;
    reg unmapped_write_flag;
    reg [15:0] h_addr;
    reg access_direction;
    reg [7:0] h_data;
    reg h_busy;
    reg h_done;
    reg x_req;
    reg x_wr;
    reg [15:0] x_addr;
    reg [7:0] x_wdata;
    wire x_done;
    wire [7:0] x_rdata;
    wire x_nack;
    wire x_arb;
    wire x_misc;
    wire x_err;
    wire apb_wr;
    wire apb_acc;
    wire [7:0] next_sum;
    reg [31:0] rd_val;
    reg rd_err;

    assign apb_acc = PSEL_I && PENABLE_I && PREADY_O;
    assign apb_wr = apb_acc && PWRITE_I;
    assign x_err = x_nack || x_arb || x_misc;
    assign next_sum = sum + x_rdata; // [RULE10]

    secl_xact u_xact (
        .clk_i(CLOCK_I),
        .nrst_i(NRST_I),
        .req_i(x_req),
        .wr_i(x_wr),
        .addr_i(x_addr),
        .wdata_i(x_wdata),
        .done_o(x_done),
        .rdata_o(x_rdata),
        .nack_o(x_nack),
        .arb_o(x_arb),
        .misc_o(x_misc),
        .eng_req_o(EE_REQ_O),
        .eng_wr_o(EE_WR_O),
        .eng_addr_o(EE_ADDR_O),
        .eng_wdata_o(EE_WDATA_O),
        .eng_done_i(EE_DONE_I),
        .eng_rdata_i(EE_RDATA_I),
        .eng_nack_i(EE_NACK_I),
        .eng_arblost_i(EE_ARBLOST_I),
        .eng_buserr_i(EE_BUSERR_I)
    );

    always @* begin
        rd_val = 32'h00000000;
        rd_err = 1'b0;
        if (PADDR_I == `SECL_OFS_CTRL) begin
            rd_val[`SECL_CTRL_IGN] = ignore_sum_errors;
            rd_val[`SECL_CTRL_RESTART] = load_run;
        end else if (PADDR_I == `SECL_OFS_STS) begin
            rd_val[`SECL_STS_DONE] = LOAD_DONE_O;
            rd_val[`SECL_STS_SUMERR] = sum_or_format_error;
            rd_val[`SECL_STS_NACK] = no_ack_error;
            rd_val[`SECL_STS_ARB] = lost_arbitration_error;
            rd_val[`SECL_STS_MISC] = misc_bus_error;
            rd_val[`SECL_STS_UNMAP] = unmapped_write_flag;
        end else if (PADDR_I == `SECL_OFS_SWITCH_CONTROL_REG) begin
            rd_val[`SECL_SW_HALT] = RESET_HALT_O;
        end else if (PADDR_I == `SECL_OFS_HACC) begin
            rd_val[15:0] = h_addr;
            rd_val[`SECL_HACC_DIR] = access_direction;
            rd_val[`SECL_HACC_BUSY] = h_busy;
            rd_val[`SECL_HACC_DONE] = h_done;
        end else if (PADDR_I == `SECL_OFS_HDATA) begin
            rd_val[7:0] = h_data;
        end else begin
            rd_err = 1'b1;
        end
    end

    // one wait state so that read data and ready both leave flops
    always @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            PREADY_O <= 1'b0;
            PRDATA_O <= 32'h00000000;
            PSLVERR_O <= 1'b0;
        end else if (PSEL_I && PENABLE_I && !PREADY_O) begin
            PREADY_O <= 1'b1;
            PRDATA_O <= PWRITE_I ? 32'h00000000 : rd_val;
            PSLVERR_O <= rd_err;
        end else begin
            PREADY_O <= 1'b0;
            PRDATA_O <= 32'h00000000;
            PSLVERR_O <= 1'b0;
        end
    end

    // software clears come first so that hardware sets below win
    always @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state <= ST_IDLE;
            phase <= PH_HDR0;
            load_run <= 1'b1;
            wrapped <= 1'b0;
            ee_addr <= 16'h0000;
            sum <= 8'h00;
            block_dword_address <= 14'h0000;
            dword_count <= 16'h0000;
            dw_data <= 32'h00000000;
            dbyte <= 2'h0;
            ignore_sum_errors <= 1'b0;
            sum_or_format_error <= 1'b0;
            no_ack_error <= 1'b0;
            lost_arbitration_error <= 1'b0;
            misc_bus_error <= 1'b0;
            unmapped_write_flag <= 1'b0;
            h_addr <= 16'h0000;
            access_direction <= 1'b0;
            h_data <= 8'h00;
            h_busy <= 1'b0;
            h_done <= 1'b0;
            x_req <= 1'b0;
            x_wr <= 1'b0;
            x_addr <= 16'h0000;
            x_wdata <= 8'h00;
            CFG_WR_O <= 1'b0;
            CFG_ADDR_O <= 16'h0000;
            CFG_DATA_O <= 32'h00000000;
            RESET_HALT_O <= 1'b0;
            LOAD_DONE_O <= 1'b0;
            EE_TARGET_O <= 7'h00;
        end else begin
            EE_TARGET_O <= `SECL_TARGET; // [RULE4]
            x_req <= 1'b0;
            CFG_WR_O <= 1'b0;
            if (apb_wr) begin
                if (PADDR_I == `SECL_OFS_CTRL) begin
                    ignore_sum_errors <= PWDATA_I[`SECL_CTRL_IGN];
                    if (PWDATA_I[`SECL_CTRL_RESTART] && !load_run && state == ST_IDLE) begin
                        load_run <= 1'b1; // [RULE1]
                        phase <= PH_HDR0;
                        ee_addr <= 16'h0000;
                        sum <= 8'h00;
                        wrapped <= 1'b0;
                        LOAD_DONE_O <= 1'b0;
                    end
                end else if (PADDR_I == `SECL_OFS_STS) begin
                    if (PWDATA_I[`SECL_STS_DONE]) LOAD_DONE_O <= 1'b0;
                    if (PWDATA_I[`SECL_STS_SUMERR]) sum_or_format_error <= 1'b0;
                    if (PWDATA_I[`SECL_STS_NACK]) no_ack_error <= 1'b0;
                    if (PWDATA_I[`SECL_STS_ARB]) lost_arbitration_error <= 1'b0;
                    if (PWDATA_I[`SECL_STS_MISC]) misc_bus_error <= 1'b0;
                    if (PWDATA_I[`SECL_STS_UNMAP]) unmapped_write_flag <= 1'b0;
                end else if (PADDR_I == `SECL_OFS_SWITCH_CONTROL_REG) begin
                    RESET_HALT_O <= PWDATA_I[`SECL_SW_HALT];
                end else if (PADDR_I == `SECL_OFS_HACC) begin
                    if (!h_busy) begin
                        h_addr <= PWDATA_I[15:0];
                        access_direction <= PWDATA_I[`SECL_HACC_DIR];
                    end
                    if (PWDATA_I[`SECL_HACC_DONE]) h_done <= 1'b0;
                end else if (PADDR_I == `SECL_OFS_HDATA) begin
                    // a start while busy is dropped, never queued
                    if (!h_busy) begin
                        h_data <= PWDATA_I[7:0]; // [RULE21] [RULE22] [RULE23]
                        h_busy <= 1'b1;
                        h_done <= 1'b0;
                    end
                end
            end
            case (state)
                ST_IDLE: begin
                    if (load_run) begin
                        if (wrapped) begin
                            sum_or_format_error <= 1'b1; // [RULE16]
                            RESET_HALT_O <= 1'b1; // [RULE13]
                            LOAD_DONE_O <= 1'b1; // [RULE14]
                            load_run <= 1'b0;
                        end else begin
                            x_req <= 1'b1; // [RULE1]
                            x_wr <= 1'b0;
                            x_addr <= ee_addr;
                            state <= ST_FETCH;
                        end
                    end else if (h_busy) begin
                        x_req <= 1'b1;
                        x_wr <= access_direction;
                        x_addr <= h_addr;
                        x_wdata <= h_data;
                        state <= ST_HOST;
                    end
                end
                ST_FETCH: begin
                    if (x_done) begin
                        state <= ST_IDLE;
                        if (x_err) begin
                            if (x_nack) no_ack_error <= 1'b1; // [RULE18]
                            if (x_arb) lost_arbitration_error <= 1'b1; // [RULE19]
                            if (x_misc) misc_bus_error <= 1'b1; // [RULE20]
                            RESET_HALT_O <= 1'b1; // [RULE13]
                            LOAD_DONE_O <= 1'b1; // [RULE14]
                            load_run <= 1'b0;
                        end else begin
                            sum <= next_sum; // [RULE10]
                            ee_addr <= ee_addr + 16'h0001;
                            if (ee_addr == `SECL_ADDR_LAST) wrapped <= 1'b1; // [RULE16]
                            case (phase)
                                PH_HDR0: begin
                                    block_dword_address[7:0] <= x_rdata;
                                    phase <= PH_HDR1;
                                end
                                PH_HDR1: begin
                                    block_dword_address[13:8] <= x_rdata[5:0]; // [RULE26]
                                    dbyte <= 2'h0;
                                    case (x_rdata[7:6])
                                        `SECL_TYPE_SINGLE: begin
                                            dword_count <= 16'h0001; // [RULE2]
                                            phase <= PH_DATA;
                                        end
                                        `SECL_TYPE_SEQ: begin
                                            phase <= PH_CNT0; // [RULE5]
                                        end
                                        `SECL_TYPE_DONE: begin
                                            // done ends the load whatever the sum
                                            load_run <= 1'b0; // [RULE8]
                                            LOAD_DONE_O <= 1'b1; // [RULE14]
                                            wrapped <= 1'b0;
                                            if (next_sum != `SECL_SUM_OK && !ignore_sum_errors) begin
                                                sum_or_format_error <= 1'b1; // [RULE15] [RULE12]
                                                RESET_HALT_O <= 1'b1;
                                            end
                                        end
                                        default: begin
                                            sum_or_format_error <= 1'b1; // [RULE17]
                                            RESET_HALT_O <= 1'b1;
                                            LOAD_DONE_O <= 1'b1;
                                            load_run <= 1'b0;
                                        end
                                    endcase
                                end
                                PH_CNT0: begin
                                    dword_count[7:0] <= x_rdata; // [RULE25]
                                    phase <= PH_CNT1;
                                end
                                PH_CNT1: begin
                                    dword_count[15:8] <= x_rdata; // [RULE6]
                                    // a zero count carries no data
                                    if (x_rdata == 8'h00 && dword_count[7:0] == 8'h00) begin
                                        phase <= PH_HDR0;
                                    end else begin
                                        phase <= PH_DATA;
                                    end
                                end
                                default: begin
                                    case (dbyte)
                                        2'h0: dw_data[7:0] <= x_rdata; // [RULE25]
                                        2'h1: dw_data[15:8] <= x_rdata;
                                        2'h2: dw_data[23:16] <= x_rdata;
                                        default: dw_data[31:24] <= x_rdata;
                                    endcase
                                    dbyte <= dbyte + 2'h1;
                                    if (dbyte == 2'h3) state <= ST_WRITE;
                                end
                            endcase
                        end
                    end
                end
                ST_WRITE: begin
                    CFG_WR_O <= 1'b1;
                    CFG_ADDR_O <= {block_dword_address, 2'b00}; // [RULE3]
                    CFG_DATA_O <= dw_data;
                    state <= ST_CHECK;
                end
                ST_CHECK: begin
                    if (CFG_UNMAPPED_I) unmapped_write_flag <= 1'b1; // [RULE9]
                    block_dword_address <= block_dword_address + 14'h0001; // [RULE7]
                    dword_count <= dword_count - 16'h0001;
                    if (dword_count == 16'h0001) phase <= PH_HDR0;
                    state <= ST_IDLE;
                end
                ST_HOST: begin
                    if (x_done) begin
                        h_busy <= 1'b0; // [RULE21] [RULE22]
                        h_done <= 1'b1;
                        if (!x_wr && !x_err) h_data <= x_rdata;
                        if (x_nack) no_ack_error <= 1'b1; // [RULE24]
                        if (x_arb) lost_arbitration_error <= 1'b1;
                        if (x_misc) misc_bus_error <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule

/* File: design/secl_xact.v */
// one eeprom byte transaction with arbitration retry and error sorting
`timescale 1ns/1ps
`include "secl_regs.vh"
module secl_xact (
    input wire clk_i,
    input wire nrst_i,
    input wire req_i,
    input wire wr_i,
    input wire [15:0] addr_i,
    input wire [7:0] wdata_i,
    output reg done_o,
    output reg [7:0] rdata_o,
    output reg nack_o,
    output reg arb_o,
    output reg misc_o,
    output reg eng_req_o,
    output reg eng_wr_o,
    output reg [15:0] eng_addr_o,
    output reg [7:0] eng_wdata_o,
    input wire eng_done_i,
    input wire [7:0] eng_rdata_i,
    input wire eng_nack_i,
    input wire eng_arblost_i,
    input wire eng_buserr_i
);
    reg [3:0] arb_cnt;
    reg retry;

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            done_o <= 1'b0;
            rdata_o <= 8'h00;
            nack_o <= 1'b0;
            arb_o <= 1'b0;
            misc_o <= 1'b0;
            eng_req_o <= 1'b0;
            eng_wr_o <= 1'b0;
            eng_addr_o <= 16'h0000;
            eng_wdata_o <= 8'h00;
            arb_cnt <= 4'h0;
            retry <= 1'b0;
        end else begin
            done_o <= 1'b0;
            nack_o <= 1'b0;
            arb_o <= 1'b0;
            misc_o <= 1'b0;
            retry <= 1'b0;
            if (req_i && !eng_req_o) begin
                eng_req_o <= 1'b1;
                eng_wr_o <= wr_i;
                eng_addr_o <= addr_i;
                eng_wdata_o <= wdata_i;
                arb_cnt <= 4'h0;
            end else if (retry) begin
                eng_req_o <= 1'b1;
            end else if (eng_req_o && eng_done_i) begin
                eng_req_o <= 1'b0;
                if (eng_buserr_i) begin
                    misc_o <= 1'b1; // [RULE20]
                    done_o <= 1'b1;
                end else if (eng_arblost_i) begin
                    // give up only after a run of lost attempts
                    if (arb_cnt == `SECL_ARB_LAST) begin
                        arb_o <= 1'b1; // [RULE19]
                        done_o <= 1'b1;
                    end else begin
                        arb_cnt <= arb_cnt + 4'h1;
                        retry <= 1'b1;
                    end
                end else if (eng_nack_i) begin
                    nack_o <= 1'b1; // [RULE18]
                    done_o <= 1'b1;
                end else begin
                    rdata_o <= eng_rdata_i;
                    done_o <= 1'b1;
                end
            end
        end
    end
endmodule
